// >>> logic/hss_pkg.sv
/*
  hss_pkg: shared constants, enumerations and carriers of the hot-swap
  start-up and fault sequencer. Assumes a single 50 MHz clock domain.
*/
package hss_pkg;

  // ----------------------------------------------------------------------
  // command codes (register offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS     = 8'h03;
  localparam logic [7:0] CMD_SUMMARY_STATUS   = 8'h79;
  localparam logic [7:0] CMD_INPUT_FAULT      = 8'h7C;
  localparam logic [7:0] CMD_VENDOR_FAULT     = 8'h80;
  localparam logic [7:0] CMD_ALERT_SUPPRESS   = 8'hD8;
  localparam logic [7:0] CMD_PIN_OVERRIDE     = 8'hD9;
  localparam logic [7:0] CMD_DIAG_FLAGS       = 8'hE1;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int SUM_INPUT_BIT     = 13;
  localparam int INP_OC_BIT        = 1;
  localparam int VND_PRESET_BIT    = 0;
  localparam int VND_BREAKER_BIT   = 1;
  localparam int DIAG_OC_BIT       = 6;
  localparam int DIAG_BREAKER_BIT  = 8;
  localparam int DIAG_LATCHED_BIT  = 4;
  localparam int MASK_OC_BIT       = 6;
  localparam int MASK_BREAKER_BIT  = 8;
  localparam int OVR_CL_EN_BIT     = 0;
  localparam int OVR_CL_VAL_BIT    = 1;
  localparam int OVR_CB_EN_BIT     = 2;
  localparam int OVR_CB_VAL_BIT    = 3;

  // ----------------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [15:0] ALERT_SUPPRESS_RST = 16'h0000;
  localparam logic [7:0]  PIN_OVERRIDE_RST   = 8'h00;
  localparam logic [2:0]  RETRY_CYCLES       = 3'h7;

  // ----------------------------------------------------------------------
  // gate drive and timer drive modes, sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    GATE_STRONG_PD   = 2'b00,
    GATE_MODERATE_PD = 2'b01,
    GATE_SOURCE      = 2'b10,
    GATE_REGULATE    = 2'b11
  } hss_gate_e;

  typedef enum logic [2:0] {
    TMR_GROUND      = 3'b000,
    TMR_CHARGE_INS  = 3'b001,
    TMR_CHARGE_FLT  = 3'b010,
    TMR_DISCH_FAST  = 3'b011,
    TMR_DISCH_SLOW  = 3'b100
  } hss_timer_e;

  typedef enum logic [2:0] {
    ST_POR      = 3'b000,
    ST_INSERT   = 3'b001,
    ST_WAIT_UV  = 3'b010,
    ST_ON       = 3'b011,
    ST_LATCHED  = 3'b100,
    ST_RETRY_DN = 3'b101,
    ST_RETRY_UP = 3'b110
  } hss_state_e;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } hss_cmd_s;

  typedef struct packed {
    logic por_ok;
    logic undervoltage_lockout;
    logic overvoltage_lockout;
    logic timer_hi;
    logic timer_lo;
    logic timer_zero;
    logic current_limit;
    logic power_limit;
    logic breaker_trip;
    logic output_feedback;
  } hss_sense_s;

endpackage

// >>> logic/hss_sequencer.sv
/*
  hss_sequencer: start-up, lockout, inrush and fault sequencing of a
  hot-swap controller with its status flags and command register access.
  Assumes comparator results arrive as clean synchronous levels and that a
  command port front end delivers one decoded command per valid cycle.
*/
`timescale 1ns/1ps

// Behaviour
// R01 - below power-on level: timer grounded, gate strongest pull-down
// R02 - after power-on level: insertion delay charges timer, gate held off
// R03 - insertion ends at timer upper threshold, then fast timer discharge
// R04 - after insertion, gate on when above undervoltage; at once if already
// R05 - limiting charges timer; if limits clear early, slow discharge
// R06 - timer upper threshold during inrush limiting declares fault, gate off
// R07 - power-good high once output feedback exceeds rising threshold
// R08 - alert line pulled low after power-on to flag default settings
// R09 - defaults-loaded flag set at power-up until clear-faults command
// R10 - inrush timeout: strong pull-down, held until restart or auto retry
// R11 - undervoltage or overvoltage lockout: gate off with moderate pull-down
// R12 - limit select low gives 25 mV limit, high gives 46 mV
// R13 - current limiting runs timer; dropping below limit resumes normal
// R14 - limiting timeout sets overcurrent flags and unmasked alert
// R15 - setup register bits override limit select input
// R16 - breaker trip: gate off at once, strong pull-down, timeout starts
// R17 - breaker clear releases strong pull-down back to limit loops
// R18 - timeout after breaker trip: moderate pull-down, fault restart handling
// R19 - breaker trip sets vendor and diagnostic flags and unmasked alert
// R20 - setup register bits override breaker factor input
// R21 - retry high latches gate off until supply cycled or enable pulled low
// R22 - auto restart cycles timer seven times before gate on again
// R23 - comparisons arrive as digital inputs; gate drive given as mode codes
module hss_sequencer (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire hss_pkg::hss_sense_s sense,
  input  wire logic                limit_select_in,
  input  wire logic                breaker_select_in,
  input  wire logic                retry_select_in,
  input  wire hss_pkg::hss_cmd_s   cmd,
  output logic [15:0]              cmd_rdata_r,
  output logic                     cmd_ack_r,
  output hss_pkg::hss_gate_e       gate_mode_r,
  output hss_pkg::hss_timer_e      timer_mode_r,
  output logic                     limit_high_r,
  output logic                     breaker_high_r,
  output logic                     power_good_out_r,
  output logic                     smba_out_r,
  output logic                     smba_oe_r
);
  import hss_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  hss_state_e  state_r;
  hss_state_e  state_nxt;
  logic        inrush_r;
  logic        breaker_seen_r;
  logic        post_ins_r;
  logic        fault_strong_r;
  logic [2:0]  retry_cnt_r;
  logic        preset_flag_r;
  logic        oc_flag_r;
  logic        breaker_flag_r;
  logic [15:0] alert_suppress_r;
  logic [7:0]  pin_override_r;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire supply_ok   = ~sense.undervoltage_lockout & ~sense.overvoltage_lockout;
  wire limiting    = sense.current_limit | sense.power_limit;
  wire timer_busy  = limiting | sense.breaker_trip;
  wire timeout     = (state_r == ST_ON) & timer_busy & sense.timer_hi;
  wire cmd_wr      = cmd.valid & cmd.write;
  wire clear_cmd   = cmd_wr & (cmd.code == CMD_CLEAR_FAULTS);
  wire wr_mask     = cmd_wr & (cmd.code == CMD_ALERT_SUPPRESS);
  wire wr_override = cmd_wr & (cmd.code == CMD_PIN_OVERRIDE);
  wire trip_event  = (state_r == ST_ON) & sense.breaker_trip;
  wire latched     = (state_r == ST_LATCHED);

  // override bits win over the strap pins
  wire limit_sel   = pin_override_r[OVR_CL_EN_BIT] ?
                     pin_override_r[OVR_CL_VAL_BIT] : limit_select_in;   // R12 R15
  wire breaker_sel = pin_override_r[OVR_CB_EN_BIT] ?
                     pin_override_r[OVR_CB_VAL_BIT] : breaker_select_in; // R20

  wire alert_any = preset_flag_r                                               // R08
                 | (oc_flag_r & ~alert_suppress_r[MASK_OC_BIT])                // R14
                 | (breaker_flag_r & ~alert_suppress_r[MASK_BREAKER_BIT]);     // R19

  // ----------------------------------------------------------------------
  // register read view
  // ----------------------------------------------------------------------
  function automatic logic [15:0] bit_at(input logic v, input int pos);
    logic [15:0] w;
    w = 16'h0000;
    w[pos] = v;
    return w;
  endfunction

  wire [15:0] summary_view = bit_at(oc_flag_r, SUM_INPUT_BIT);                 // R14
  wire [15:0] input_view   = bit_at(oc_flag_r, INP_OC_BIT);
  wire [15:0] vendor_view  = bit_at(preset_flag_r, VND_PRESET_BIT)             // R09
                           | bit_at(breaker_flag_r, VND_BREAKER_BIT);
  wire [15:0] diag_view    = bit_at(oc_flag_r, DIAG_OC_BIT)
                           | bit_at(breaker_flag_r, DIAG_BREAKER_BIT)
                           | bit_at(latched, DIAG_LATCHED_BIT);
  wire [15:0] read_view    =
      (cmd.code == CMD_SUMMARY_STATUS) ? summary_view :
      (cmd.code == CMD_INPUT_FAULT)    ? input_view :
      (cmd.code == CMD_VENDOR_FAULT)   ? vendor_view :
      (cmd.code == CMD_ALERT_SUPPRESS) ? alert_suppress_r :
      (cmd.code == CMD_PIN_OVERRIDE)   ? {8'h00, pin_override_r} :
      (cmd.code == CMD_DIAG_FLAGS)     ? diag_view : 16'h0000;

  // ----------------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POR: begin
        if (sense.por_ok) begin
          state_nxt = ST_INSERT;                                           // R02
        end
      end
      ST_INSERT: begin
        if (sense.timer_hi) begin
          state_nxt = supply_ok ? ST_ON : ST_WAIT_UV;                      // R03 R04
        end
      end
      ST_WAIT_UV: begin
        if (supply_ok) begin
          state_nxt = ST_ON;                                               // R04
        end
      end
      ST_ON: begin
        if (!supply_ok) begin
          state_nxt = ST_WAIT_UV;                                          // R11
        end else if (timeout) begin
          state_nxt = retry_select_in ? ST_LATCHED : ST_RETRY_DN;          // R06 R18
        end
      end
      ST_LATCHED: begin
        // a pulse on the enable level or a supply cycle is the only way out
        if (sense.undervoltage_lockout && sense.timer_zero) begin
          state_nxt = ST_WAIT_UV;                                          // R21
        end
      end
      ST_RETRY_DN: begin
        if (retry_cnt_r == RETRY_CYCLES) begin
          if (sense.timer_zero) begin
            state_nxt = ST_WAIT_UV;                                        // R22
          end
        end else if (sense.timer_lo) begin
          state_nxt = ST_RETRY_UP;
        end
      end
      ST_RETRY_UP: begin
        if (sense.timer_hi) begin
          state_nxt = ST_RETRY_DN;                                         // R22
        end
      end
      default: state_nxt = ST_POR;
    endcase
    if (!sense.por_ok) begin
      state_nxt = ST_POR;                                                  // R01
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // inrush, breaker and retry bookkeeping
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || state_r != ST_ON) begin
      inrush_r       <= (state_nxt == ST_ON);
      breaker_seen_r <= 1'b0;
      post_ins_r     <= (state_nxt == ST_ON);
    end else begin
      if (!timer_busy) begin
        inrush_r       <= 1'b0;                                            // R05 R13
        breaker_seen_r <= 1'b0;
      end else if (sense.breaker_trip) begin
        breaker_seen_r <= 1'b1;                                            // R16
      end
      if (sense.timer_zero || timer_busy) begin
        post_ins_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_strong_r <= 1'b0;
    end else if (timeout) begin
      fault_strong_r <= inrush_r & ~breaker_seen_r;                        // R10 R18
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || state_r == ST_ON) begin
      retry_cnt_r <= 3'h0;
    end else if (state_r == ST_RETRY_UP && sense.timer_hi) begin
      retry_cnt_r <= retry_cnt_r + 3'h1;                                   // R22
    end
  end

  // ----------------------------------------------------------------------
  // drive modes
  // ----------------------------------------------------------------------
  hss_gate_e  gate_nxt;
  hss_timer_e timer_nxt;

  always_comb begin
    gate_nxt  = GATE_MODERATE_PD;
    timer_nxt = TMR_DISCH_SLOW;
    case (state_nxt)
      ST_POR: begin
        gate_nxt  = GATE_STRONG_PD;                                        // R01
        timer_nxt = TMR_GROUND;
      end
      ST_INSERT: begin
        gate_nxt  = GATE_MODERATE_PD;                                      // R02
        timer_nxt = TMR_CHARGE_INS;
      end
      ST_WAIT_UV: begin
        gate_nxt  = GATE_MODERATE_PD;                                      // R11
        timer_nxt = TMR_DISCH_FAST;                                        // R03
      end
      ST_ON: begin
        if (sense.breaker_trip) begin
          gate_nxt = GATE_STRONG_PD;                                       // R16
        end else if (limiting) begin
          gate_nxt = GATE_REGULATE;                                        // R17
        end else begin
          gate_nxt = GATE_SOURCE;                                          // R04
        end
        if (timer_busy) begin
          timer_nxt = TMR_CHARGE_FLT;                                      // R05 R13
        end else if (post_ins_r || state_r != ST_ON) begin
          timer_nxt = TMR_DISCH_FAST;                                      // R03
        end else begin
          timer_nxt = TMR_DISCH_SLOW;                                      // R05
        end
      end
      ST_LATCHED, ST_RETRY_DN: begin
        gate_nxt  = fault_strong_r ? GATE_STRONG_PD : GATE_MODERATE_PD;    // R10 R18
        timer_nxt = TMR_DISCH_SLOW;                                        // R21
      end
      ST_RETRY_UP: begin
        gate_nxt  = fault_strong_r ? GATE_STRONG_PD : GATE_MODERATE_PD;
        timer_nxt = TMR_CHARGE_FLT;                                        // R22
      end
      default: begin
        gate_nxt  = GATE_STRONG_PD;
        timer_nxt = TMR_GROUND;
      end
    endcase
    // the fault decision must not wait a cycle in the gate path
    if (state_r == ST_ON && timeout) begin
      gate_nxt = (inrush_r & ~breaker_seen_r) ? GATE_STRONG_PD : GATE_MODERATE_PD; // R06
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gate_mode_r  <= GATE_STRONG_PD;
      timer_mode_r <= TMR_GROUND;
    end else begin
      gate_mode_r  <= gate_nxt;                                            // R23
      timer_mode_r <= timer_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // sticky flags: set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      preset_flag_r  <= 1'b0;
      oc_flag_r      <= 1'b0;
      breaker_flag_r <= 1'b0;
    end else begin
      if (state_r == ST_POR && sense.por_ok) begin
        preset_flag_r <= 1'b1;                                             // R09
      end else if (clear_cmd) begin
        preset_flag_r <= 1'b0;
      end
      if (timeout) begin
        oc_flag_r <= 1'b1;                                                 // R14
      end else if (clear_cmd) begin
        oc_flag_r <= 1'b0;
      end
      if (trip_event) begin
        breaker_flag_r <= 1'b1;                                            // R19
      end else if (clear_cmd) begin
        breaker_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // command port and configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      alert_suppress_r <= ALERT_SUPPRESS_RST;
      pin_override_r   <= PIN_OVERRIDE_RST;
    end else begin
      if (wr_mask) begin
        alert_suppress_r <= cmd.wdata;
      end
      if (wr_override) begin
        pin_override_r <= cmd.wdata[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_ack_r   <= 1'b0;
      cmd_rdata_r <= 16'h0000;
    end else begin
      cmd_ack_r   <= cmd.valid;
      cmd_rdata_r <= (cmd.valid && !cmd.write) ? read_view : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      limit_high_r     <= 1'b0;
      breaker_high_r   <= 1'b0;
      power_good_out_r <= 1'b0;
      smba_out_r       <= 1'b0;
      smba_oe_r        <= 1'b0;
    end else begin
      limit_high_r     <= limit_sel;                                       // R12
      breaker_high_r   <= breaker_sel;                                     // R20
      power_good_out_r <= sense.output_feedback & (state_r == ST_ON);      // R07
      smba_out_r       <= 1'b0;
      smba_oe_r        <= alert_any;                                       // R08
    end
  end

endmodule // hss_sequencer

// >>> tb/hss_cap_model.sv
/*
  hss_cap_model: timer capacitor and its comparators, in steps of 10 mV.
  Assumes the sequencer's timer mode selects the current into the capacitor.
*/
`timescale 1ns/1ps
module hss_cap_model (
  input  wire hss_pkg::hss_timer_e timer_mode_r,
  input  wire logic                mclk,
  output logic                     timer_hi,
  output logic                     timer_lo,
  output logic                     timer_zero
);
  import hss_pkg::*;
  // --------------------------------------------------------------------
  // capacitor
  // --------------------------------------------------------------------
  int v = 0;
  // fault charge is faster than insertion charge, as on the real pin
  always @(posedge mclk) begin
    case (timer_mode_r)
      TMR_CHARGE_INS: v <= (v < 200) ? v + 1 : v;
      TMR_CHARGE_FLT: v <= (v < 200) ? v + 2 : v;
      TMR_DISCH_FAST: v <= (v > 10) ? v - 10 : 0;
      TMR_DISCH_SLOW: v <= (v > 0) ? v - 1 : 0;
      default:        v <= 0;
    endcase
  end
  assign timer_hi   = (v >= 170);
  assign timer_lo   = (v <= 100);
  assign timer_zero = (v <= 30);
endmodule // hss_cap_model

// >>> tb/hss_sequencer_asserts.sv
/*
  hss_sequencer_asserts: port-level checks of the sequencer.
  Assumes one clock domain; bound to every sequencer instance below.
*/
`timescale 1ns/1ps
module hss_sequencer_asserts (
  input wire logic                mclk,
  input wire logic                rst,
  input wire hss_pkg::hss_sense_s sense,
  input wire hss_pkg::hss_cmd_s   cmd,
  input wire hss_pkg::hss_gate_e  gate_mode_r,
  input wire hss_pkg::hss_timer_e timer_mode_r,
  input wire logic                power_good_out_r,
  input wire logic                smba_oe_r
);
  import hss_pkg::*;
  // --------------------------------------------------------------------
  // helpers and properties
  // --------------------------------------------------------------------
  wire sup_ok = sense.por_ok & ~sense.undervoltage_lockout & ~sense.overvoltage_lockout;
  wire quiet  = ~sense.current_limit & ~sense.power_limit & ~sense.breaker_trip;
  wire is_on  = gate_mode_r inside {GATE_SOURCE, GATE_REGULATE};
  wire in_ins = timer_mode_r == TMR_CHARGE_INS && gate_mode_r == GATE_MODERATE_PD;
  wire clr    = cmd.valid && cmd.write && cmd.code == CMD_CLEAR_FAULTS;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_ins_end; in_ins && sense.timer_hi; endsequence
  sequence s_clear; clr && is_on && quiet && !sense.timer_hi ##1 quiet; endsequence
  property p_por_hold;
    !sense.por_ok |=> gate_mode_r == GATE_STRONG_PD && timer_mode_r == TMR_GROUND;
  endproperty
  property p_preset; in_ins [*2] |-> smba_oe_r; endproperty
  property p_ins_on;
    s_ins_end ##0 sup_ok && quiet |=>
      gate_mode_r == GATE_SOURCE && timer_mode_r == TMR_DISCH_FAST;
  endproperty
  property p_ins_uv;
    s_ins_end ##0 sense.por_ok && !sup_ok |=> gate_mode_r == GATE_MODERATE_PD;
  endproperty
  property p_pgood; power_good_out_r |-> $past(sense.output_feedback); endproperty
  property p_lockout;
    is_on && quiet && sense.por_ok && !sup_ok |=> gate_mode_r == GATE_MODERATE_PD;
  endproperty
  property p_breaker;
    is_on && sense.breaker_trip && sup_ok && !sense.timer_hi |=> gate_mode_r == GATE_STRONG_PD;
  endproperty
  property p_charge;
    is_on && sup_ok && !sense.timer_hi && !sense.breaker_trip
      && (sense.current_limit || sense.power_limit) |=> timer_mode_r == TMR_CHARGE_FLT;
  endproperty
  property p_clear; s_clear |=> !smba_oe_r; endproperty
  a_por_hold: assert property (p_por_hold) else $error("gate or timer not held at power-on");
  a_preset: assert property (p_preset) else $error("alert not raised after power-on");
  a_ins_on: assert property (p_ins_on) else $error("gate not on after insertion");
  a_ins_uv: assert property (p_ins_uv) else $error("gate on below lockout");
  a_pgood: assert property (p_pgood) else $error("power good without feedback");
  a_lockout: assert property (p_lockout) else $error("lockout not moderate pull-down");
  a_breaker: assert property (p_breaker) else $error("breaker not strong pull-down");
  a_charge: assert property (p_charge) else $error("timer not charging in limit");
  a_clear: assert property (p_clear) else $error("alert kept after clear");
endmodule // hss_sequencer_asserts

bind hss_sequencer hss_sequencer_asserts i_hss_sequencer_asserts (
  .mclk(mclk), .rst(rst), .sense(sense), .cmd(cmd), .gate_mode_r(gate_mode_r),
  .timer_mode_r(timer_mode_r), .power_good_out_r(power_good_out_r), .smba_oe_r(smba_oe_r));

// >>> tb/test_hss_sequencer.sv
/*
  test_hss_sequencer: self-checking bench of the sequencer.
  Assumes hss_cap_model stands in for the timer capacitor.
*/
`timescale 1ns/1ps
module test_hss_sequencer;
  import hss_pkg::*;
  // --------------------------------------------------------------------
  // stimulus, design and partner
  // --------------------------------------------------------------------
  logic        mclk = 1'b0, rst = 1'b1, por = 1'b0, uv = 1'b0, ov = 1'b0, fb = 1'b0;
  logic        cl = 1'b0, pl = 1'b0, brk = 1'b0, lim_sel = 1'b0, brk_sel = 1'b0;
  logic        rty_sel = 1'b1, t_hi, t_lo, t_zero, ack, lim_hi, brk_hi, pgood, a_out, a_oe;
  logic [15:0] rdata, d, exp_q[$], msk_q[$];
  logic [31:0] seed = 32'h63AB6B81;
  hss_cmd_s    cmd = '0;
  hss_sense_s  sense;
  hss_gate_e   gate;
  hss_timer_e  tmode, prev;
  int          errors = 0, n_tests = 0, n, k;

  always #10 mclk = ~mclk;
  assign sense = {por, uv, ov, t_hi, t_lo, t_zero, cl, pl, brk, fb};
  hss_sequencer i_hss_sequencer (.mclk(mclk), .rst(rst), .sense(sense), .limit_select_in(lim_sel),
    .breaker_select_in(brk_sel), .retry_select_in(rty_sel), .cmd(cmd), .cmd_rdata_r(rdata),
    .cmd_ack_r(ack), .gate_mode_r(gate), .timer_mode_r(tmode), .limit_high_r(lim_hi),
    .breaker_high_r(brk_hi), .power_good_out_r(pgood), .smba_out_r(a_out), .smba_oe_r(a_oe));
  hss_cap_model i_hss_cap_model (.timer_mode_r(tmode), .mclk(mclk), .timer_hi(t_hi),
    .timer_lo(t_lo), .timer_zero(t_zero));

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // the expected word is noted before the request, masked to the bits in question
  task automatic cmd_op(input logic w, input logic [7:0] c, input logic [15:0] wd,
                        input logic [15:0] e, input logic [15:0] m);
    @(negedge mclk);
    cmd <= '{1'b1, w, c, wd};
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(negedge mclk);
    cmd.valid <= 1'b0;
  endtask
  task automatic wait_gate(input hss_gate_e g, input int lim);
    k = 0;
    while (gate !== g && k < lim) begin
      @(negedge mclk);
      k++;
    end
    check(gate, g);
    if (gate !== g) finish_test();
  endtask
  always @(negedge mclk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() > 0) check(rdata & msk_q.pop_front(), exp_q.pop_front());
      else begin
        errors++;
        $display("wrong value at %0t: answer without request", $time);
      end
    end
  end

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    check(gate, GATE_STRONG_PD);
    check(tmode, TMR_GROUND);
    por = 1'b1;
    @(negedge mclk);
    check(gate, GATE_MODERATE_PD);
    check(tmode, TMR_CHARGE_INS);
    @(negedge mclk);
    check(a_oe, 1'b1);
    check(a_out, 1'b0);
    wait_gate(GATE_SOURCE, 250);
    check(tmode, TMR_DISCH_FAST);
    cmd_op(1'b0, CMD_VENDOR_FAULT, 16'h0000, 16'h0001, 16'h0001);
    cmd_op(1'b0, 8'h55, 16'h0000, 16'h0000, 16'hFFFF);
    fb = 1'b1;
    @(negedge mclk);
    check(pgood, 1'b1);
    repeat (200) @(negedge mclk);
    for (int i = 0; i < 2; i++) begin
      {cl, pl} = 2'b10 >> i;
      @(negedge mclk);
      check(tmode, TMR_CHARGE_FLT);
      repeat (40) @(negedge mclk);
      {cl, pl} = 2'b00;
      @(negedge mclk);
      check(tmode, TMR_DISCH_SLOW);
      check(gate, GATE_SOURCE);
      repeat (100) @(negedge mclk);
    end
    for (int i = 0; i < 16; i++) begin
      {lim_sel, brk_sel} = 2'(lfsr());
      cmd_op(1'b1, CMD_PIN_OVERRIDE, 16'(i), 16'h0000, 16'hFFFF);
      repeat (2) @(negedge mclk);
      check(lim_hi, i[0] ? i[1] : lim_sel);
      check(brk_hi, i[2] ? i[3] : brk_sel);
    end
    for (int i = 0; i < 2; i++) begin
      {uv, ov} = 2'b10 >> i;
      @(negedge mclk);
      check(gate, GATE_MODERATE_PD);
      {uv, ov} = 2'b00;
      wait_gate(GATE_SOURCE, 300);
    end
    d = 16'(lfsr());
    cmd_op(1'b1, CMD_ALERT_SUPPRESS, d, 16'h0000, 16'hFFFF);
    cmd_op(1'b0, CMD_ALERT_SUPPRESS, 16'h0000, d, 16'hFFFF);
    cmd_op(1'b1, CMD_ALERT_SUPPRESS, 16'h0100, 16'h0000, 16'hFFFF);
    cmd_op(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 16'h0000, 16'hFFFF);
    cmd_op(1'b0, CMD_VENDOR_FAULT, 16'h0000, 16'h0000, 16'h0001);
    check(a_oe, 1'b0);
    // breaker alert masked, overcurrent alert left open
    {cl, brk} = 2'b11;
    @(negedge mclk);
    check(gate, GATE_STRONG_PD);
    cmd_op(1'b0, CMD_VENDOR_FAULT, 16'h0000, 16'h0002, 16'h0002);
    cmd_op(1'b0, CMD_DIAG_FLAGS, 16'h0000, 16'h0100, 16'h0100);
    check(a_oe, 1'b0);
    brk = 1'b0;
    @(negedge mclk);
    check(gate, GATE_REGULATE);
    wait_gate(GATE_MODERATE_PD, 300);
    cmd_op(1'b0, CMD_INPUT_FAULT, 16'h0000, 16'h0002, 16'h0002);
    cmd_op(1'b0, CMD_SUMMARY_STATUS, 16'h0000, 16'h2000, 16'h2000);
    cmd_op(1'b0, CMD_DIAG_FLAGS, 16'h0000, 16'h0050, 16'h0050);
    check(a_oe, 1'b1);
    cl = 1'b0;
    repeat (300) @(negedge mclk);
    check(gate, GATE_MODERATE_PD);
    uv = 1'b1;
    repeat (3) @(negedge mclk);
    uv = 1'b0;
    wait_gate(GATE_SOURCE, 300);
    // inrush timeout with automatic restart
    rty_sel = 1'b0;
    por = 1'b0;
    @(negedge mclk);
    check(gate, GATE_STRONG_PD);
    {por, uv, cl} = 3'b111;
    repeat (200) @(negedge mclk);
    uv = 1'b0;
    wait_gate(GATE_STRONG_PD, 300);
    cl = 1'b0;
    n = 0;
    k = 0;
    prev = tmode;
    while (gate !== GATE_SOURCE && k < 3000) begin
      @(negedge mclk);
      if (tmode === TMR_CHARGE_FLT && prev !== TMR_CHARGE_FLT) n++;
      prev = tmode;
      k++;
    end
    check(16'(n), 16'h0007);
    check(gate, GATE_SOURCE);
    finish_test();
  end
endmodule // test_hss_sequencer
